// ===== indmon_pkg.sv
// Constants for the indicator status monitor
package indmon_pkg;
    localparam int NUM_IND = 10;
    localparam int NUM_SIG = 4;
    localparam int NAME_LEN = 32;
    localparam int NAME_WORDS = NUM_IND * NAME_LEN;
    localparam int ADDR_W = 8;

    // Flag positions in a decoded state and in an event code
    localparam int SIG_INTER = 0;
    localparam int SIG_OPEN = 1;
    localparam int SIG_CLOSE = 2;
    localparam int SIG_BAD = 3;
    localparam logic [3:0] STATE_RST = 4'h1;

    // Register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_IRQ_STS = 8'h04;
    localparam logic [7:0] ADR_IRQ_CLR = 8'h08;
    localparam logic [7:0] ADR_IRQ_EN = 8'h0C;
    localparam logic [7:0] ADR_SINGLE = 8'h10;
    localparam logic [7:0] ADR_TIME = 8'h14;
    localparam logic [7:0] ADR_NAME_PTR = 8'h18;
    localparam logic [7:0] ADR_NAME_DATA = 8'h1C;
    localparam logic [7:0] ADR_EVSEL0 = 8'h20;
    localparam logic [7:0] ADR_STATE_LO = 8'h48;
    localparam logic [7:0] ADR_STATE_HI = 8'h4C;

    // Reset values
    localparam logic CTRL_RUN_RST = 1'b0;
    localparam logic [7:0] EVSEL_RST = 8'hFF;
    localparam logic [9:0] SINGLE_RST = 10'h000;
    localparam logic [9:0] IRQ_EN_RST = 10'h000;

    // Time stamp tick
    localparam int CLK_PERIOD_NS = 50;
    localparam int STAMP_RES_MS = 1;
    localparam int MS_CYCLES = STAMP_RES_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [1:0] SETTLE_DONE = 2'h3;
endpackage : indmon_pkg

// ===== indmon_dec_if.sv
// Link between the monitor and one indicator decoder
`timescale 1ns/1ps
interface indmon_dec_if;
    logic open_in;
    logic close_in;
    logic arm;
    logic [3:0] state;
    logic [3:0] on_evt;
    logic [3:0] off_evt;

    modport dec (
        input open_in, close_in, arm,
        output state, on_evt, off_evt
    );
    modport mon (
        output open_in, close_in, arm,
        input state, on_evt, off_evt
    );
endinterface : indmon_dec_if

// ===== indmon_decoder.sv
// One indicator: status decode and change detection
`timescale 1ns/1ps
module indmon_decoder (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    indmon_dec_if.dec dec
);
    typedef struct packed {
        logic armed;
        logic [3:0] state;
        logic [3:0] on_evt;
        logic [3:0] off_evt;
    } indmon_dec_state_t;

    indmon_dec_state_t s;
    indmon_dec_state_t n;
    logic [3:0] decoded;

    always_comb begin
        decoded = '0;
        case ({dec.open_in, dec.close_in})
            2'b10: decoded[indmon_pkg::SIG_OPEN] = 1'b1;
            2'b01: decoded[indmon_pkg::SIG_CLOSE] = 1'b1;
            2'b11: decoded[indmon_pkg::SIG_BAD] = 1'b1;
            default: decoded[indmon_pkg::SIG_INTER] = 1'b1;
        endcase
    end

    always_comb begin
        n = s;
        n.on_evt = '0;
        n.off_evt = '0;
        if (!dec.arm) begin
            n.armed = 1'b0;
        end else if (!s.armed) begin
            // First evaluation loads the state silently
            n.armed = 1'b1;
            n.state = decoded;
        end else begin
            n.state = decoded;
            n.on_evt = decoded & ~s.state;
            n.off_evt = s.state & ~decoded;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= '{armed: 1'b0, state: indmon_pkg::STATE_RST,
                   on_evt: 4'h0, off_evt: 4'h0};
        end else begin
            s <= n;
        end
    end

    assign dec.state = s.state;
    assign dec.on_evt = s.on_evt;
    assign dec.off_evt = s.off_evt;
endmodule : indmon_decoder

// ===== indmon_top.sv
// Indicator status monitor: ten indicators, events, registers
`timescale 1ns/1ps
module indmon_top #(
    parameter int P_MS_CYCLES = indmon_pkg::MS_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [9:0] i_open,
    input wire logic [9:0] i_close,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic [39:0] o_state,
    output logic o_evt_valid,
    output logic [3:0] o_evt_inst,
    output logic [1:0] o_evt_sig,
    output logic o_evt_on,
    output logic [31:0] o_evt_stamp
);
    typedef struct packed {
        logic [9:0] open_m;
        logic [9:0] open_s;
        logic [9:0] close_m;
        logic [9:0] close_s;
        logic [1:0] settle;
        logic [15:0] div;
        logic [31:0] ms;
        logic run;
        logic [9:0] single;
        logic [9:0] irq_sts;
        logic [9:0] irq_en;
        logic [8:0] name_ptr;
        logic [79:0] evsel;
        logic [79:0] pend;
        logic [319:0] stamp;
        logic [31:0] rdata;
        logic irq;
        logic evt_valid;
        logic [3:0] evt_inst;
        logic [1:0] evt_sig;
        logic evt_on;
        logic [31:0] evt_stamp;
        logic [39:0] state;
    } indmon_state_t;

    localparam logic [15:0] MS_LAST = 16'(P_MS_CYCLES - 1);
    localparam logic [8:0] NAME_END = 9'(indmon_pkg::NAME_WORDS);

    indmon_state_t s;
    indmon_state_t n;
    logic [7:0] name_mem [0:indmon_pkg::NAME_WORDS-1];
    logic [39:0] dec_state;
    logic [39:0] dec_on;
    logic [39:0] dec_off;
    logic [79:0] new_pend;
    logic [9:0] irq_set;
    logic arm;
    logic [6:0] pick;
    logic [3:0] wslot;
    logic wslot_ok;
    logic [3:0] rslot;
    logic rslot_ok;
    logic [7:0] name_rd;

    // Lowest pending event; instance 0 Intermediate ON first
    function automatic logic [6:0] first_pending(input logic [79:0] p);
        logic [6:0] idx;
        idx = 7'h00;
        for (int k = 79; k >= 0; k--) begin
            if (p[k]) begin
                idx = 7'(k);
            end
        end
        return idx;
    endfunction : first_pending

    // Event selection slot addressed, if any
    function automatic logic [4:0] evsel_slot(input logic [7:0] a);
        logic [7:0] off;
        off = a - indmon_pkg::ADR_EVSEL0;
        if (a >= indmon_pkg::ADR_EVSEL0 && off[1:0] == 2'h0
            && off[7:2] < 6'(indmon_pkg::NUM_IND)) begin
            return {1'b1, off[5:2]};
        end
        return 5'h00;
    endfunction : evsel_slot

    assign arm = s.run && (s.settle == indmon_pkg::SETTLE_DONE);
    assign {wslot_ok, wslot} = evsel_slot(i_addr);
    assign {rslot_ok, rslot} = evsel_slot(i_addr);
    assign pick = first_pending(s.pend);
    assign name_rd = (s.name_ptr < NAME_END) ? name_mem[s.name_ptr] : 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < indmon_pkg::NUM_IND; gi++) begin : g_ind
            indmon_dec_if u_link ();
            assign u_link.open_in = s.open_s[gi];
            // One input and its inverse in single mode
            assign u_link.close_in = s.single[gi] ? ~s.open_s[gi]
                                                  : s.close_s[gi];
            assign u_link.arm = arm;
            assign dec_state[gi*4 +: 4] = u_link.state;
            assign dec_on[gi*4 +: 4] = u_link.on_evt;
            assign dec_off[gi*4 +: 4] = u_link.off_evt;
            // Keep only the selected transitions
            assign new_pend[gi*8 +: 8] =
                {dec_off[gi*4 +: 4], dec_on[gi*4 +: 4]}
                & s.evsel[gi*8 +: 8];
            assign irq_set[gi] = |new_pend[gi*8 +: 8];
            indmon_decoder u_dec (
                .i_sys_clk(i_sys_clk),
                .i_nrst(i_nrst),
                .dec(u_link)
            );
        end
    endgenerate

    always_comb begin
        n = s;
        n.open_m = i_open;
        n.open_s = s.open_m;
        n.close_m = i_close;
        n.close_s = s.close_m;
        if (s.settle != indmon_pkg::SETTLE_DONE) begin
            n.settle = s.settle + 2'h1;
        end
        // Millisecond time base for stamps
        if (s.div == MS_LAST) begin
            n.div = 16'h0000;
            n.ms = s.ms + 32'h0000_0001;
        end else begin
            n.div = s.div + 16'h0001;
        end
        n.state = dec_state;

        // Hand one pending event per cycle to the event buffer
        n.evt_valid = 1'b0;
        if (|s.pend) begin
            n.evt_valid = 1'b1;
            n.evt_inst = pick[6:3];
            n.evt_sig = pick[1:0];
            n.evt_on = ~pick[2];
            n.evt_stamp = s.stamp[{pick[6:3], 5'h00} +: 32];
            n.pend[pick] = 1'b0;
        end
        for (int i = 0; i < indmon_pkg::NUM_IND; i++) begin
            if (irq_set[i]) begin
                n.stamp[i*32 +: 32] = s.ms;
            end
        end
        // New events win over the one just served
        n.pend = n.pend | new_pend;

        if (i_wr) begin
            case (i_addr)
                indmon_pkg::ADR_CTRL: n.run = i_wdata[0];
                indmon_pkg::ADR_IRQ_EN: n.irq_en = i_wdata[9:0];
                indmon_pkg::ADR_SINGLE: begin
                    if (!s.run) begin
                        n.single = i_wdata[9:0];
                    end
                end
                indmon_pkg::ADR_NAME_PTR: n.name_ptr = i_wdata[8:0];
                default: begin
                    if (wslot_ok && !s.run) begin
                        n.evsel[{wslot, 3'h0} +: 8] = i_wdata[7:0];
                    end
                end
            endcase
        end
        n.irq_sts = s.irq_sts;
        if (i_wr && i_addr == indmon_pkg::ADR_IRQ_CLR) begin
            n.irq_sts = s.irq_sts & ~i_wdata[9:0];
        end
        n.irq_sts = n.irq_sts | irq_set;
        n.irq = |(n.irq_sts & n.irq_en);

        n.rdata = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                indmon_pkg::ADR_CTRL: n.rdata = {31'h0, s.run};
                indmon_pkg::ADR_IRQ_STS: n.rdata = {22'h0, s.irq_sts};
                indmon_pkg::ADR_IRQ_EN: n.rdata = {22'h0, s.irq_en};
                indmon_pkg::ADR_SINGLE: n.rdata = {22'h0, s.single};
                indmon_pkg::ADR_TIME: n.rdata = s.ms;
                indmon_pkg::ADR_NAME_PTR: n.rdata = {23'h0, s.name_ptr};
                indmon_pkg::ADR_NAME_DATA: n.rdata = {24'h0, name_rd};
                indmon_pkg::ADR_STATE_LO: n.rdata = s.state[31:0];
                indmon_pkg::ADR_STATE_HI: n.rdata = {24'h0, s.state[39:32]};
                default: begin
                    if (rslot_ok) begin
                        n.rdata = {24'h0, s.evsel[{rslot, 3'h0} +: 8]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= '0;
            s.run <= indmon_pkg::CTRL_RUN_RST;
            s.single <= indmon_pkg::SINGLE_RST;
            s.irq_en <= indmon_pkg::IRQ_EN_RST;
            s.evsel <= {indmon_pkg::NUM_IND{indmon_pkg::EVSEL_RST}};
            s.state <= {indmon_pkg::NUM_IND{indmon_pkg::STATE_RST}};
        end else begin
            s <= n;
        end
    end

    // Names are stored only while stopped; no reset on the memory
    always_ff @(posedge i_sys_clk) begin
        if (i_wr && !s.run && i_addr == indmon_pkg::ADR_NAME_DATA
            && s.name_ptr < NAME_END) begin
            name_mem[s.name_ptr] <= i_wdata[7:0];
        end
    end

    assign o_rdata = s.rdata;
    assign o_irq = s.irq;
    assign o_state = s.state;
    assign o_evt_valid = s.evt_valid;
    assign o_evt_inst = s.evt_inst;
    assign o_evt_sig = s.evt_sig;
    assign o_evt_on = s.evt_on;
    assign o_evt_stamp = s.evt_stamp;
endmodule : indmon_top

// ===== indmon_properties.sv
// Port checks for the indicator monitor
`timescale 1ns/1ps
module indmon_properties (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [9:0] i_open,
    input wire logic [9:0] i_close,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic [39:0] o_state,
    input wire logic o_evt_valid,
    input wire logic [3:0] o_evt_inst
);
    logic run_ff;
    logic [39:0] prev_ff;
    logic [7:0] quiet_ff;
    logic oh_ok;
    logic op0;
    logic cl0;
    logic sgl0_ff;
    logic cl_eff;
    // Close source of indicator 0 as the design sees it
    assign cl_eff = sgl0_ff ? !i_open[0] : i_close[0];
    assign op0 = run_ff && i_open[0];
    assign cl0 = run_ff && cl_eff;
    always_comb begin
        oh_ok = 1'b1;
        for (int i = 0; i < 10; i++) begin
            oh_ok = oh_ok && $onehot(o_state[4*i +: 4]);
        end
    end
    // Cycles since the decoded state last moved
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            run_ff <= 1'b0;
            sgl0_ff <= 1'b0;
            prev_ff <= 40'h1111111111;
            quiet_ff <= 8'h00;
        end else begin
            if (i_wr && i_addr == indmon_pkg::ADR_CTRL) begin
                run_ff <= i_wdata[0];
            end
            if (i_wr && i_addr == indmon_pkg::ADR_SINGLE && !run_ff) begin
                sgl0_ff <= i_wdata[0];
            end
            prev_ff <= o_state;
            if (o_state != prev_ff) begin
                quiet_ff <= 8'h00;
            end else if (quiet_ff != 8'hFF) begin
                quiet_ff <= quiet_ff + 8'h01;
            end
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    a_state_onehot: assert property (oh_ok)
        else $error("state flags not one-hot");
    a_reset_state: assert property ($rose(i_nrst) |->
        o_state == 40'h1111111111) else $error("state after reset");
    a_evt_quiet: assert property (o_evt_valid |-> quiet_ff < 8'h64)
        else $error("event without state change");
    a_evt_inst_range: assert property (
        o_evt_valid |-> o_evt_inst <= 4'h9)
        else $error("event instance out of range");
    a_open_decode: assert property ((op0 && !cl_eff)[*6] |->
        o_state[3:0] == 4'h2) else $error("open decode");
    a_close_decode: assert property ((cl0 && !i_open[0])[*6] |->
        o_state[3:0] == 4'h4) else $error("close decode");
    a_bad_decode: assert property ((op0 && cl_eff)[*6] |->
        o_state[3:0] == 4'h8) else $error("bad decode");
    a_inter_decode: assert property ((run_ff && !i_open[0] &&
        !cl_eff)[*6] |-> o_state[3:0] == 4'h1) else $error("inter decode");
endmodule : indmon_properties

// ===== indmon_contacts.sv
// Auxiliary contact model driving the status inputs
`timescale 1ns/1ps
module indmon_contacts (
    input wire logic i_sys_clk,
    input wire logic [9:0] i_want_open,
    input wire logic [9:0] i_want_close,
    input wire logic [9:0] i_single,
    output logic [9:0] o_open = 10'h000,
    output logic [9:0] o_close = 10'h000
);
    logic [9:0] junk_ff = 10'h155;
    always @(posedge i_sys_clk) begin
        junk_ff <= ~junk_ff;
        o_open <= i_want_open;
        // Single-input indicators have no close wire: the line wanders
        o_close <= (i_want_close & ~i_single) | (junk_ff & i_single);
    end
endmodule : indmon_contacts

// ===== indmon_bench.sv
// Self-checking bench for the indicator monitor
`timescale 1ns/1ps
module indmon_bench;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [9:0] i_open, i_close, o_w = 10'h000, c_w = 10'h000;
    logic [9:0] single = 10'h200;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h00000000, seed = 32'h70D55179, t0, v;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata, o_evt_stamp;
    logic [39:0] o_state;
    logic o_irq, o_evt_valid, o_evt_on;
    logic [3:0] o_evt_inst;
    logic [1:0] o_evt_sig;
    logic [6:0] first_evt;
    logic [31:0] first_stamp;
    logic [39:0] exp_v;
    int n_fail = 0, checks_done = 0, n_evt = 0, cyc = 0;
    indmon_top #(.P_MS_CYCLES(20)) u_indmon_top (.i_sys_clk, .i_nrst,
        .i_open, .i_close, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq,
        .o_state, .o_evt_valid, .o_evt_inst, .o_evt_sig, .o_evt_on,
        .o_evt_stamp);
    indmon_contacts u_indmon_contacts (.i_sys_clk, .i_want_open(o_w),
        .i_want_close(c_w), .i_single(single), .o_open(i_open),
        .o_close(i_close));
    initial forever #25 i_sys_clk = ~i_sys_clk;
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    always @(posedge i_sys_clk) begin
        cyc++;
        if (o_evt_valid === 1'b1) begin
            if (n_evt == 0) begin
                first_evt = {o_evt_inst, o_evt_sig, o_evt_on};
                first_stamp = o_evt_stamp;
            end
            n_evt++;
        end
        if (cyc == 5000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input string s, input logic [39:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        d = o_rdata;
    endtask : rd
    function automatic logic [39:0] exp_st(input logic [9:0] op, cl, sg);
        logic [39:0] s;
        logic c;
        for (int i = 0; i < 10; i++) begin
            c = sg[i] ? ~op[i] : cl[i];
            s[4*i +: 4] = (op[i] & c) ? 4'h8 : op[i] ? 4'h2 : c ? 4'h4 : 4'h1;
        end
        return s;
    endfunction : exp_st
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        @(negedge i_sys_clk);
        chk("reset state", 40'h1111111111, o_state);
        rd(indmon_pkg::ADR_EVSEL0 + 8'h24, v);
        chk("evsel9", 32'h000000FF, v);
        rd(8'h50, v);
        chk("unmapped", 32'h00000000, v);
        wr(indmon_pkg::ADR_NAME_PTR, 32'h0000013F);
        wr(indmon_pkg::ADR_NAME_DATA, 32'h0000005A);
        rd(indmon_pkg::ADR_NAME_DATA, v);
        chk("name char", 32'h0000005A, v);
        wr(indmon_pkg::ADR_SINGLE, 32'h00000200);
        wr(indmon_pkg::ADR_EVSEL0 + 8'h04, 32'h00000002);
        wr(indmon_pkg::ADR_IRQ_EN, 32'h00000003);
        n_evt = 0;
        wr(indmon_pkg::ADR_CTRL, 32'h00000001);
        wr(indmon_pkg::ADR_SINGLE, 32'h00000000);
        rd(indmon_pkg::ADR_SINGLE, v);
        chk("single held", 32'h00000200, v);
        repeat (20) @(negedge i_sys_clk);
        chk("silent load", 0, n_evt);
        chk("loaded", exp_st(0, 0, single), o_state);
        $display("setup test done");
        // Detection lies within a few cycles, so at most one tick later
        rd(indmon_pkg::ADR_TIME, t0);
        @(posedge i_sys_clk);
        o_w <= 10'h003;
        repeat (30) @(negedge i_sys_clk);
        chk("event count", 3, n_evt);
        chk("first event", 7'h03, first_evt);
        chk("stamp", 1'b1, (first_stamp - t0) <= 32'h00000001);
        repeat (40) @(negedge i_sys_clk);
        chk("no repeat", 3, n_evt);
        chk("irq", 1'b1, o_irq);
        rd(indmon_pkg::ADR_IRQ_STS, v);
        chk("irq status", 32'h00000003, v);
        wr(indmon_pkg::ADR_IRQ_CLR, 32'h00000003);
        repeat (3) @(negedge i_sys_clk);
        chk("irq cleared", 1'b0, o_irq);
        $display("event test done");
        rd(indmon_pkg::ADR_TIME, t0);
        repeat (98) @(posedge i_sys_clk);
        rd(indmon_pkg::ADR_TIME, v);
        chk("ms ticks", 32'h00000005, v - t0);
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            @(posedge i_sys_clk);
            o_w <= seed[9:0];
            c_w <= seed[19:10];
            repeat (12) @(negedge i_sys_clk);
            exp_v = exp_st(o_w, c_w, single);
            chk("state", exp_v, o_state);
        end
        rd(indmon_pkg::ADR_STATE_LO, v);
        chk("state lo", exp_v[31:0], v);
        rd(indmon_pkg::ADR_STATE_HI, v);
        chk("state hi", exp_v[39:32], v);
        $display("random test done");
        print_verdict();
    end
endmodule : indmon_bench
bind indmon_top indmon_properties u_indmon_properties (.i_sys_clk, .i_nrst,
    .i_open, .i_close, .i_addr, .i_wdata, .i_wr, .o_state, .o_evt_valid,
    .o_evt_inst);
